// file: inc/rclk_params.svh
`ifndef RCLK_PARAMS_SVH
`define RCLK_PARAMS_SVH
// register map and fields
`define RCLK_CTRL_ADDR 5'h17
`define RCLK_ENABLE_BIT 15
`define RCLK_SRC_HI 14
`define RCLK_SRC_LO 11
`define RCLK_FREQ_HI 10
`define RCLK_FREQ_LO 8
`define RCLK_SQL_HI 5
`define RCLK_SQL_LO 4
`define RCLK_TYPE_HI 2
`define RCLK_TYPE_LO 0
`define RCLK_CTRL_RESET 16'h0000
`define RCLK_WRITE_MASK 16'hFF37
`define RCLK_NUM_PORTS 4
`endif

// file: inc/rclk_pkg.sv
package rclk_pkg;
	typedef logic [15:0] word_t;
	typedef logic [4:0] addr_t;
	typedef enum logic [1:0] {SQL_STRICT, SQL_RELAXED, SQL_LINK_ONLY, SQL_OFF} squelch_t;
	typedef enum logic [2:0] {FREQ_25, FREQ_125, FREQ_31P25} freq_t;
	typedef enum logic [2:0] {SRC_SERIAL, SRC_COPPER_RX, SRC_COPPER_TX} ctype_t;
endpackage

// file: design/recovered_clock_output_select.sv
`timescale 1ns/1ps
`include "rclk_params.svh"
// Behaviour
// - bit 15 enables output, resets off
// - bits 14:11 pick source port 0-3
// - bits 10:8 pick output frequency
// - squelch 00: down, unstable, master/10M, EEE
// - squelch 01: allow master/10M, LPI clocks
// - squelch 10: squelch only when link down
// - squelch 11: never auto squelch
// - squelch pin overrides every setting
// - bits 2:0 pick clock type
module recovered_clock_output_select #(
	parameter int NPORT = `RCLK_NUM_PORTS
)(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire rclk_pkg::addr_t regAddr,
	input wire rclk_pkg::word_t regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output rclk_pkg::word_t regRdData,
	input wire logic [NPORT-1:0] serialClk,
	input wire logic [NPORT-1:0] copperRxClk,
	input wire logic [NPORT-1:0] copperTxClk,
	input wire logic [NPORT-1:0] linkUp,
	input wire logic [NPORT-1:0] linkStable,
	input wire logic [NPORT-1:0] masterOr10,
	input wire logic [NPORT-1:0] eeeMode,
	input wire logic [NPORT-1:0] lpiReceive,
	input wire logic clockSquelchIn,
	output logic recovered_clock_one_out,
	output logic [2:0] outFreqSel
);
	import rclk_pkg::*;

	// ************************************
	// control register
	// ************************************
	word_t ctrl;
	wire ctrlHit = (regAddr == `RCLK_CTRL_ADDR);
	// reserved bits 7:6 and 3 stay zero through the mask
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl <= `RCLK_CTRL_RESET;
		else if (regWrite && ctrlHit)
			ctrl <= regWrData & `RCLK_WRITE_MASK;
	end

	// read data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			regRdData <= '0;
		else if (regRead && ctrlHit)
			regRdData <= ctrl;
		else
			regRdData <= '0;
	end

	// ************************************
	// field decode
	// ************************************
	// reserved codes of every field decode alike: at or above the limit is refused
	function automatic logic codeBelow(input logic [3:0] code, input int limit);
		return int'(code) < limit;
	endfunction

	// one bit of a per-port vector; a port beyond the vector reads as low
	function automatic logic pickPort(input logic [NPORT-1:0] vec, input logic [1:0] sel);
		return (int'(sel) < NPORT) ? vec[sel] : 1'b0;
	endfunction

	wire enable = ctrl[`RCLK_ENABLE_BIT];
	// source port, reserved codes select nothing
	wire [3:0] srcSel = ctrl[`RCLK_SRC_HI:`RCLK_SRC_LO];
	wire srcValid = codeBelow(srcSel, NPORT);
	// only the low two bits index a port; srcValid already refuses the rest
	wire [1:0] port = srcSel[1:0];
	// frequency code handed on; reserved codes keep the output off
	wire [2:0] freqSel = ctrl[`RCLK_FREQ_HI:`RCLK_FREQ_LO];
	wire freqValid = codeBelow({1'b0, freqSel}, int'(FREQ_31P25) + 1);
	wire [1:0] sqlSel = ctrl[`RCLK_SQL_HI:`RCLK_SQL_LO];
	// clock type, reserved codes keep the output off
	wire [2:0] typeSel = ctrl[`RCLK_TYPE_HI:`RCLK_TYPE_LO];
	wire typeValid = codeBelow({1'b0, typeSel}, int'(SRC_COPPER_TX) + 1);

	// ************************************
	// status synchronisers (pins, foreign domain)
	// ************************************
	localparam int NSTAT = 5*NPORT + 1;
	// pins packed in one vector: squelch pin on top, then one group per status kind
	wire [NSTAT-1:0] statusPins = {clockSquelchIn, lpiReceive, eeeMode, masterOr10, linkStable,
		linkUp};
	logic [NSTAT-1:0] stMeta;
	logic [NSTAT-1:0] stSync;
	// two-stage synchroniser; only the second stage reads the first
	// source clocks are not synchronised: they clock the output stage directly
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stMeta <= '0;
			stSync <= '0;
		end
		else
		begin
			stMeta <= statusPins;
			stSync <= stMeta;
		end
	end
	// synchronised status, one vector per kind
	wire [NPORT-1:0] stUp = stSync[NPORT-1:0];
	wire [NPORT-1:0] stStable = stSync[2*NPORT-1:NPORT];
	wire [NPORT-1:0] stMaster = stSync[3*NPORT-1:2*NPORT];
	wire [NPORT-1:0] stEee = stSync[4*NPORT-1:3*NPORT];
	wire [NPORT-1:0] stLpi = stSync[5*NPORT-1:4*NPORT];
	wire pinSquelch = stSync[5*NPORT];

	// ************************************
	// squelch policy
	// ************************************
	// squelch decision of one port under the programmed policy; a pure function so that
	// every port is judged alike and the selected one is a plain pick
	function automatic logic squelchFor(
		input logic [1:0] policy,
		input logic up,
		input logic stable,
		input logic master,
		input logic eee,
		input logic lpi
	);
		case (squelch_t'(policy))
			SQL_STRICT: return !up || !stable || master || eee;
			// relaxed, master/10M allowed and EEE allowed during LPI
			SQL_RELAXED: return !up || !stable || (eee && !lpi);
			SQL_LINK_ONLY: return !up;
			SQL_OFF: return 1'b0;
			// unreachable with a two-bit code; fails towards squelch
			default: return 1'b1;
		endcase
	endfunction

	// one decision per port
	wire [NPORT-1:0] portSquelch;
	for (genvar k = 0; k < NPORT; k++)
	begin : g_squelch
		assign portSquelch[k] = squelchFor(sqlSel, stUp[k], stStable[k], stMaster[k], stEee[k],
			stLpi[k]);
	end
	wire autoSquelch = pickPort(portSquelch, port);

	// every reason for an off output meets here; the pin sits outside the policy so that
	// no register setting can undo it
	// pin wins over enable, source and squelch settings
	wire fieldsValid = srcValid && typeValid && freqValid;
	wire next_gate = !pinSquelch && enable && fieldsValid && !autoSquelch;

	// ************************************
	// clock mux and glitch-free gate
	// ************************************
	// type mux (raw clocks; glitch safety comes from the gate below)
	// limitation: change port or type only while the output is off; a switch while
	// running can clip one source cycle before the gate reacts
	wire rawClk = (typeSel == 3'(SRC_SERIAL)) ? pickPort(serialClk, port) :
		(typeSel == 3'(SRC_COPPER_RX)) ? pickPort(copperRxClk, port) :
		pickPort(copperTxClk, port);

	// gate decision taken in core_clk, then retimed through two flops on the selected clock's rising edge
	logic gateReq;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			gateReq <= 1'b0;
		else
			gateReq <= next_gate;
	end

	// output is a flop on the selected clock, toggling only while gated, reset low
	logic gateMeta, gateOn;
	always_ff @(posedge rawClk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			gateMeta <= 1'b0;
			gateOn <= 1'b0;
		end
		else
		begin
			gateMeta <= gateReq;
			gateOn <= gateMeta;
		end
	end

	// limitation: output toggles at half the selected rate; a full-rate drive needs analog
	// clock gating outside this block. stops only after a high phase, so no runt pulse
	always_ff @(posedge rawClk or negedge rst_b)
	begin
		if (!rst_b)
			recovered_clock_one_out <= 1'b0;
		else if (gateOn)
			recovered_clock_one_out <= !recovered_clock_one_out;
		else
			recovered_clock_one_out <= 1'b0;
	end

	// registered copy of the frequency code for the downstream synthesiser
	// it lags the register write by one clock; a reserved code is passed on as written
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			outFreqSel <= 3'(FREQ_25);
		else
			outFreqSel <= freqSel;
	end
endmodule

// file: bench/rclk_asserts.sv
`timescale 1ns/1ps
// ****
// checker
// ****
module rclk_asserts #(
	parameter int NPORT = 4
)(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire rclk_pkg::addr_t regAddr,
	input wire rclk_pkg::word_t regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire rclk_pkg::word_t regRdData,
	input wire logic [NPORT-1:0] linkUp,
	input wire logic [NPORT-1:0] masterOr10,
	input wire logic clockSquelchIn,
	input wire logic recovered_clock_one_out,
	input wire logic [2:0] outFreqSel
);
	import rclk_pkg::*;
	word_t ctrl;
	logic [4:0] oc;
	wire [1:0] p = ctrl[12:11];
	// causes that must hold the pin low, except an unstable link and EEE; gating takes a few source edges, so wait 31
	wire off = !ctrl[15] || clockSquelchIn || ctrl[14:13] != 0 || ctrl[2:0] > 2 || ctrl[10:8] > 2
		|| (ctrl[5:4] != 3 && !linkUp[p]) || (ctrl[5:4] == 0 && masterOr10[p]);
	// shadow of the control word and a saturating off counter
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctrl <= '0;
		else if (regWrite && regAddr == 5'h17)
			ctrl <= regWrData & 16'hFF37;
	end
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			oc <= '0;
		else if (!off)
			oc <= '0;
		else if (!(&oc))
			oc <= oc + 5'd1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	AST_RD: assert property (regRead && regAddr == 5'h17 |=> regRdData == $past(ctrl))
		else $error("read data differs from control word");
	AST_RD0: assert property (!regRead || regAddr != 5'h17 |=> regRdData == '0)
		else $error("read data not zero");
	AST_FREQ: assert property (outFreqSel == $past(ctrl[10:8]))
		else $error("frequency select differs");
	AST_DIS: assert property (&oc && !ctrl[15] |-> !recovered_clock_one_out)
		else $error("disabled output not low");
	AST_PIN: assert property (&oc && clockSquelchIn |-> !recovered_clock_one_out)
		else $error("pin squelch ignored");
	AST_SRC: assert property (&oc && ctrl[14:13] != 0 |-> !recovered_clock_one_out)
		else $error("reserved source drives output");
	AST_LINK: assert property (&oc && ctrl[5:4] != 3 && !linkUp[p] |-> !recovered_clock_one_out)
		else $error("link down not squelched");
	AST_STRICT: assert property (&oc && ctrl[5:4] == 0 && masterOr10[p] |-> !recovered_clock_one_out)
		else $error("strict squelch ignored");
	cover property (&oc && clockSquelchIn);
	cover property ($rose(recovered_clock_one_out));
	cover property (regWrite ##1 regRead);
endmodule
bind recovered_clock_output_select rclk_asserts #(.NPORT(NPORT)) i_rclk_asserts (
	.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .linkUp(linkUp),
	.masterOr10(masterOr10), .clockSquelchIn(clockSquelchIn),
	.recovered_clock_one_out(recovered_clock_one_out), .outFreqSel(outFreqSel));

// file: bench/rclk_sink.sv
`timescale 1ns/1ps
// ****
// board timing sink
// ****
module rclk_sink (
	input wire logic clkIn,
	input wire logic sqReq,
	output logic clockSquelchIn,
	output int edges
);
	assign clockSquelchIn = sqReq;
	// edge count; a squelched clock adds none
	initial edges = 0;
	always @(posedge clkIn) edges++;
endmodule

// file: bench/recovered_clock_output_select_tb_top.sv
`timescale 1ns/1ps
// ****
// bench top
// ****
module recovered_clock_output_select_tb_top;
	import rclk_pkg::*;
	logic core_clk = 0, rst_b = 0, regWrite = 0, regRead = 0, sqReq = 0, sqPin, outPin;
	addr_t regAddr = 0;
	word_t regWrData = 0, regRdData;
	logic [3:0] up = 0, stab = 0, mast = 0, eee = 0, lpi = 0;
	logic [2:0] cnt = 0, freq;
	int fails = 0, numChecks = 0, edges;
	always #20 core_clk = ~core_clk;
	// three source rates from one counter
	always @(posedge core_clk) cnt <= cnt + 3'd1;
	recovered_clock_output_select i_recovered_clock_output_select (.core_clk(core_clk),
		.rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .serialClk({4{cnt[0]}}),
		.copperRxClk({4{cnt[1]}}), .copperTxClk({4{cnt[2]}}), .linkUp(up), .linkStable(stab),
		.masterOr10(mast), .eeeMode(eee), .lpiReceive(lpi), .clockSquelchIn(sqPin),
		.recovered_clock_one_out(outPin), .outFreqSel(freq));
	rclk_sink i_rclk_sink (.clkIn(outPin), .sqReq(sqReq), .clockSquelchIn(sqPin), .edges(edges));
	task automatic chk(input word_t got, input word_t exp);
		numChecks++;
		if (got !== exp)
		begin
			fails++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input word_t d);
		@(posedge core_clk);
		regAddr <= 5'h17;
		regWrData <= d;
		regWrite <= 1;
		@(posedge core_clk);
		regWrite <= 0;
	endtask
	task automatic rd(input addr_t a, input word_t e);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1;
		@(posedge core_clk);
		regRead <= 0;
		@(negedge core_clk);
		chk(regRdData, e);
	endtask
	// write, let gating settle, then see whether the pin toggles
	task automatic tog(input word_t w, input bit exp);
		int e0;
		wr(w);
		repeat (40) @(posedge core_clk);
		e0 = edges;
		repeat (40) @(posedge core_clk);
		chk(word_t'(edges != e0), word_t'(exp));
	endtask
	task automatic t_regs;
		int i;
		rd(5'h17, 16'h0000);
		wr(16'hFFFF);
		rd(5'h17, 16'hFF37);
		rd(5'h10, 16'h0000);
		for (i = 0; i < 3; i++)
		begin
			wr(word_t'(i) << 8);
			repeat (2) @(negedge core_clk);
			chk(word_t'(freq), word_t'(i));
		end
	endtask
	task automatic t_squelch;
		@(posedge core_clk);
		up <= 4'hF;
		stab <= 4'hF;
		mast <= 4'h4;
		tog(16'h9001, 0);
		tog(16'h9011, 1);
		tog(16'h9021, 1);
		stab <= 4'hB;
		tog(16'h9011, 0);
		tog(16'h9021, 1);
		stab <= 4'hF;
		mast <= 4'h0;
		eee <= 4'h4;
		tog(16'h9001, 0);
		lpi <= 4'h4;
		tog(16'h9011, 1);
		up <= 4'h0;
		tog(16'h9021, 0);
		tog(16'h9031, 1);
		sqReq <= 1;
		tog(16'h9031, 0);
		sqReq <= 0;
	endtask
	task automatic t_select;
		tog(16'h9032, 1);
		tog(16'h9033, 0);
		tog(16'hA030, 0);
		tog(16'h1030, 0);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", numChecks, fails);
		if (fails == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		t_regs;
		t_squelch;
		t_select;
		tally_and_finish;
	end
	initial
	begin
		repeat (5000) @(posedge core_clk);
		fails++;
		tally_and_finish;
	end
endmodule
